// *** common/tbi_consts.svh ***
// constants for the time base and interval timer block: register indices,
// field positions, reset values and timing counts.
// assumes a 100 MHz pclk and a 32.768 kHz sub-clock arriving on a pin.
//
// Functional notes
// - bit 3 set: timer a counts sub-clock prescaler
// - time base source is 32.768 kHz sub-clock
// - time base, select 100 holds counter reset
// - time base, select 001 overflows every 0.5 s
// - reload bit clear: timer c wraps freely
// - direction bits 00 make timer c count up
// - select 011 clocks timer c at phi/64
// - load register holds the timer c reload value
// - timer c overflow interval is 3.2768 ms
`ifndef TBI_CONSTS_SVH
`define TBI_CONSTS_SVH

// register indices; byte address is four times the index
`define TBI_IDX_TA_MODE 18'h0ffb0
`define TBI_IDX_TC_MODE 18'h0ffb4
`define TBI_IDX_TC_LOAD 18'h0ffb5
`define TBI_IDX_STATUS 18'h0ffb8
`define TBI_IDX_COUNT 18'h0ffb9

// timer a mode fields
`define TBI_TA_TB_BIT 3
`define TBI_TA_SEL_HI 2
`define TBI_TA_SEL_LO 0
`define TBI_TA_RESET_SEL 3'h4
`define TBI_TA_MODE_MASK 8'h0f

// timer c mode fields
`define TBI_TC_RELOAD_BIT 7
`define TBI_TC_DIR_HI 6
`define TBI_TC_DIR_LO 5
`define TBI_TC_SEL_HI 2
`define TBI_TC_SEL_LO 0
`define TBI_TC_MODE_MASK 8'he7

// status fields
`define TBI_ST_TA_OVF 0
`define TBI_ST_TC_OVF 1

// reset values
`define TBI_TA_MODE_RST 8'h00
`define TBI_TC_MODE_RST 8'h00
`define TBI_TC_LOAD_RST 8'h00

// timing: pclk, system clock phi, sub-clock
`define TBI_CLK_HZ 100000000
`define TBI_PHI_HZ 5000000
`define TBI_PHI_DIV (`TBI_CLK_HZ / `TBI_PHI_HZ)
`define TBI_SUB_HZ 32768
`define TBI_PSC_S_BITS 13
`define TBI_PSC_W_BITS 7

`endif

// *** common/tbi_pkg.sv ***
// types shared by the timer block files.
// assumes tbi_consts.svh supplies the numeric constants.
package tbi_pkg;
    // timer c count direction, from the two direction bits
    typedef enum logic [1:0] {
        TBI_DIR_UP = 2'b00,
        TBI_DIR_DOWN = 2'b01,
        TBI_DIR_UP_B = 2'b10,
        TBI_DIR_UP_C = 2'b11
    } tbi_dir_t;
endpackage

// *** common/tbi_psc_if.sv ***
// prescaler outputs passed from the prescaler module to the timers.
// assumes every signal is on pclk.
`timescale 1ns/1ps
interface tbi_psc_if;
    logic phi_tick; // one pclk per phi period
    logic [12:0] psc_s; // phi prescaler count
    logic sub_tick; // one pclk per sub-clock rising edge
    logic [6:0] psc_w; // sub-clock prescaler count
    modport src (output phi_tick, psc_s, sub_tick, psc_w);
    modport sink (input phi_tick, psc_s, sub_tick, psc_w);
endinterface

// *** verilog/tbi_prescaler.sv ***
// system clock and sub-clock prescalers for the timer block.
// assumes sub_clk_pin is asynchronous to pclk and much slower.
`timescale 1ns/1ps
`include "tbi_consts.svh"
module tbi_prescaler (
    input wire logic pclk, // 100 MHz clock
    input wire logic presetn, // async reset, active low
    input wire logic sub_clk_pin, // 32.768 kHz sub-clock pin
    tbi_psc_if.src psc // prescaler outputs
);
    localparam logic [4:0] PHI_LAST = 5'(`TBI_PHI_DIV - 1);

    logic [4:0] phi_cnt; // pclk cycles within one phi period
    logic sub_meta; // first synchroniser stage
    logic sub_sync; // second synchroniser stage
    logic sub_prev; // delayed copy for edge detect

    // phi derived from pclk so phi/64 keeps its real period
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            phi_cnt <= 5'h00;
            psc.phi_tick <= 1'b0;
        end else begin
            psc.phi_tick <= (phi_cnt == PHI_LAST);
            phi_cnt <= (phi_cnt == PHI_LAST) ? 5'h00 : phi_cnt + 5'h01;
        end
    end

    // prescaler s counts phi periods
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            psc.psc_s <= 13'h0000;
        end else if (psc.phi_tick) begin
            psc.psc_s <= psc.psc_s + 13'h0001;
        end
    end

    // two flops before anything looks at the pin
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sub_meta <= 1'b0;
            sub_sync <= 1'b0;
            sub_prev <= 1'b0;
        end else begin
            sub_meta <= sub_clk_pin;
            sub_sync <= sub_meta;
            sub_prev <= sub_sync;
        end
    end

    // prescaler w counts sub-clock rising edges
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            psc.sub_tick <= 1'b0;
            psc.psc_w <= 7'h00;
        end else begin
            psc.sub_tick <= sub_sync & ~sub_prev;
            if (sub_sync & ~sub_prev) begin
                psc.psc_w <= psc.psc_w + 7'h01;
            end
        end
    end
endmodule

// *** verilog/tbi_top.sv ***
// time base timer a and interval timer c behind an apb slave.
// assumes an apb master on pclk and a 32.768 kHz sub-clock pin; the
// display digit sequencer sits outside and follows tc_ovf_pulse.
//
// Design decision made here: the APB slave port.
`timescale 1ns/1ps
`include "tbi_consts.svh"
module tbi_top (
    input wire logic pclk, // 100 MHz clock
    input wire logic presetn, // async reset, active low
    input wire logic psel, // apb select
    input wire logic penable, // apb access phase
    input wire logic pwrite, // apb direction, high for write
    input wire logic [19:0] paddr, // apb byte address
    input wire logic [31:0] pwdata, // apb write data
    input wire logic sub_clk_pin, // 32.768 kHz sub-clock
    output logic [31:0] prdata, // apb read data
    output logic pready, // apb ready
    output logic pslverr, // apb error, unmapped address
    output logic ta_ovf_flag, // timer a overflow flag, sticky
    output logic tc_ovf_flag, // timer c overflow flag, sticky
    output logic tc_ovf_pulse // one pclk per timer c overflow
);
    tbi_psc_if psc (); // prescaler outputs

    logic [7:0] timer_a_mode; // timer a mode register
    logic [7:0] timer_c_mode; // timer c mode register
    logic [7:0] timer_c_reload_value; // timer c load register
    logic [7:0] timer_a_counter; // timer a count
    logic [7:0] timer_c_counter; // timer c count
    logic ta_tick; // timer a count event
    logic tc_tick; // timer c count event
    logic ta_hold; // timer a held in reset
    logic ta_wrap; // timer a overflow this cycle
    logic tc_wrap; // timer c overflow or underflow this cycle
    logic tc_down; // timer c counting down
    logic [2:0] ta_sel; // timer a clock select field
    logic [2:0] tc_sel; // timer c clock select field
    logic acc; // apb access phase seen
    logic wr_now; // write taken this edge
    logic clr_ta; // software clears timer a flag
    logic clr_tc; // software clears timer c flag
    logic [31:0] next_rdata; // read mux
    logic next_err; // unmapped address

    // true when a free-running count has all low k bits set
    function automatic logic tap_hit(input logic [12:0] c,
                                     input logic [3:0] k);
        logic [12:0] mask;
        mask = 13'h1fff >> (4'd13 - k);
        return (c & mask) == mask;
    endfunction

    // register index decode, bits above the index must be zero
    function automatic logic reg_hit(input logic [19:0] a,
                                     input logic [17:0] idx);
        return a[19:2] == idx;
    endfunction

    // phi divider exponent for timer c clock select
    function automatic logic [3:0] tc_shift(input logic [2:0] s);
        logic [3:0] k;
        case (s)
            3'h0: k = 4'd13; // phi/8192
            3'h1: k = 4'd11; // phi/2048
            3'h2: k = 4'd9; // phi/512
            3'h3: k = 4'd6; // phi/64
            3'h4: k = 4'd4; // phi/16
            3'h5: k = 4'd2; // phi/4
            default: k = 4'd1; // phi/2
        endcase
        return k;
    endfunction

    tbi_prescaler u_psc (
        .pclk(pclk),
        .presetn(presetn),
        .sub_clk_pin(sub_clk_pin),
        .psc(psc)
    );

    assign ta_sel = timer_a_mode[`TBI_TA_SEL_HI:`TBI_TA_SEL_LO];
    assign tc_sel = timer_c_mode[`TBI_TC_SEL_HI:`TBI_TC_SEL_LO];

    // timer a source: sub-clock prescaler in time base mode
    always_comb begin
        ta_hold = 1'b0;
        if (timer_a_mode[`TBI_TA_TB_BIT]) begin
            // sel 000 -> 1 s, 001 -> 0.5 s, 010/011 faster
            ta_tick = psc.sub_tick &&
                tap_hit({6'h00, psc.psc_w}, 4'd7 - {2'b00, ta_sel[1:0]});
            // bit 2 stops and clears the time base
            ta_hold = (ta_sel == `TBI_TA_RESET_SEL) || ta_sel[2];
        end else begin
            // interval mode from phi, reuses the timer c taps
            ta_tick = psc.phi_tick && tap_hit(psc.psc_s, tc_shift(ta_sel));
        end
    end

    assign ta_wrap = ta_tick && !ta_hold && (timer_a_counter == 8'hff);

    // timer a counter
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            timer_a_counter <= 8'h00;
        end else if (ta_hold) begin
            timer_a_counter <= 8'h00;
        end else if (ta_tick) begin
            timer_a_counter <= timer_a_counter + 8'h01;
        end
    end

    // timer c source and direction
    assign tc_tick = psc.phi_tick && tap_hit(psc.psc_s, tc_shift(tc_sel));
    assign tc_down = tbi_pkg::tbi_dir_t'(timer_c_mode[`TBI_TC_DIR_HI:
        `TBI_TC_DIR_LO]) == tbi_pkg::TBI_DIR_DOWN;
    assign tc_wrap = tc_tick &&
        (tc_down ? (timer_c_counter == 8'h00) : (timer_c_counter == 8'hff));

    // timer c counter; reload replaces the wrap when enabled
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            timer_c_counter <= 8'h00;
        end else if (tc_wrap && timer_c_mode[`TBI_TC_RELOAD_BIT]) begin
            timer_c_counter <= timer_c_reload_value;
        end else if (tc_tick && tc_down) begin
            timer_c_counter <= timer_c_counter - 8'h01;
        end else if (tc_tick) begin
            timer_c_counter <= timer_c_counter + 8'h01;
        end
    end

    // overflow pulse paces the outside digit sequencer
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tc_ovf_pulse <= 1'b0;
        end else begin
            tc_ovf_pulse <= tc_wrap;
        end
    end

    // apb: access phase waits one cycle, answer registered
    assign acc = psel && penable && !pready;
    assign wr_now = psel && penable && pready && pwrite && !pslverr;
    assign clr_ta = wr_now && reg_hit(paddr, `TBI_IDX_STATUS) &&
        pwdata[`TBI_ST_TA_OVF];
    assign clr_tc = wr_now && reg_hit(paddr, `TBI_IDX_STATUS) &&
        pwdata[`TBI_ST_TC_OVF];

    // sticky flags, a new overflow wins over a clear
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ta_ovf_flag <= 1'b0;
            tc_ovf_flag <= 1'b0;
        end else begin
            ta_ovf_flag <= ta_wrap | (ta_ovf_flag & ~clr_ta);
            tc_ovf_flag <= tc_wrap | (tc_ovf_flag & ~clr_tc);
        end
    end

    // read mux and unmapped check, computed at the access cycle
    always_comb begin
        next_rdata = 32'h0000_0000;
        next_err = 1'b0;
        if (reg_hit(paddr, `TBI_IDX_TA_MODE)) begin
            next_rdata = {24'h00_0000, timer_a_mode};
        end else if (reg_hit(paddr, `TBI_IDX_TC_MODE)) begin
            next_rdata = {24'h00_0000, timer_c_mode};
        end else if (reg_hit(paddr, `TBI_IDX_TC_LOAD)) begin
            next_rdata = {24'h00_0000, timer_c_reload_value};
        end else if (reg_hit(paddr, `TBI_IDX_STATUS)) begin
            next_rdata = {30'h0000_0000, tc_ovf_flag, ta_ovf_flag};
        end else if (reg_hit(paddr, `TBI_IDX_COUNT)) begin
            next_rdata = {16'h0000, timer_c_counter, timer_a_counter};
        end else begin
            next_err = 1'b1; // unmapped: error, reads zero
        end
    end

    // answer flops; pready high for exactly one cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
        end else begin
            pready <= acc;
            pslverr <= acc && next_err;
            if (acc && !pwrite) begin
                prdata <= next_rdata;
            end
        end
    end

    // mode and load registers, written at the completing edge
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            timer_a_mode <= `TBI_TA_MODE_RST;
            timer_c_mode <= `TBI_TC_MODE_RST;
            timer_c_reload_value <= `TBI_TC_LOAD_RST;
        end else if (wr_now) begin
            if (reg_hit(paddr, `TBI_IDX_TA_MODE)) begin
                timer_a_mode <= pwdata[7:0] & `TBI_TA_MODE_MASK;
            end
            if (reg_hit(paddr, `TBI_IDX_TC_MODE)) begin
                timer_c_mode <= pwdata[7:0] & `TBI_TC_MODE_MASK;
            end
            if (reg_hit(paddr, `TBI_IDX_TC_LOAD)) begin
                timer_c_reload_value <= pwdata[7:0];
            end
        end
    end
endmodule

// *** sim/tbi_props.sv ***
// assertion checker for the timer block apb slave and timer c overflow outputs.
// assumes it is bound to tbi_top and sees only that module's ports.
`timescale 1ns/1ps
module tbi_props (
    input wire logic pclk, // 100 mhz clock
    input wire logic presetn, // async reset, active low
    input wire logic psel, // apb select
    input wire logic penable, // apb access phase
    input wire logic pwrite, // apb direction
    input wire logic [31:0] prdata, // apb read data
    input wire logic pready, // apb ready
    input wire logic pslverr, // apb error
    input wire logic tc_ovf_flag, // timer c flag
    input wire logic tc_ovf_pulse // timer c overflow pulse
);
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    // first access cycle, slave not yet ready
    sequence s_wait;
        psel && penable && !pready;
    endsequence
    // an overflow event; the fastest legal period is 40 pclk
    sequence s_event;
        tc_ovf_pulse;
    endsequence
    a_ready_next: assert property (s_wait |=> pready)
        else $error("ready late");
    a_ready_once: assert property (pready |=> !pready)
        else $error("ready stuck");
    a_err_ready: assert property (pslverr |-> pready)
        else $error("error without ready");
    a_ready_cause: assert property (pready |-> $past(psel && penable))
        else $error("ready without access");
    a_err_zero: assert property (pready && pslverr && !pwrite |->
        prdata == 32'h0)
        else $error("error read data nonzero");
    a_pulse_gap: assert property (s_event |=> !tc_ovf_pulse [*8])
        else $error("overflow pulses too close");
    a_pulse_flag: assert property (s_event |-> ##[0:1] tc_ovf_flag)
        else $error("flag missing after pulse");
    a_flag_clear: assert property ($fell(tc_ovf_flag) |->
        $past(psel && penable && pwrite && pready))
        else $error("flag cleared without write");
endmodule
bind tbi_top tbi_props i_props (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .tc_ovf_flag(tc_ovf_flag),
    .tc_ovf_pulse(tc_ovf_pulse));

// *** sim/time_base_and_interval_timers_test.sv ***
// self-checking bench for the timer block over apb.
// assumes the checker is bound in and the sub-clock is sped up here.
`timescale 1ns/1ps
`include "tbi_consts.svh"
module time_base_and_interval_timers_test;
    logic pclk = 1'b0; // bench clock
    logic presetn = 1'b0; // reset, active low
    logic psel = 1'b0; // apb select
    logic penable = 1'b0; // apb enable
    logic pwrite = 1'b0; // apb direction
    logic [19:0] paddr = 20'h0; // apb address
    logic [31:0] pwdata = 32'h0; // apb write data
    logic sub_clk_pin = 1'b0; // sub-clock, still between bursts
    logic [31:0] prdata; // read data
    logic pready; // ready
    logic pslverr; // error
    logic ta_ovf_flag; // timer a flag
    logic tc_ovf_flag; // timer c flag
    logic tc_ovf_pulse; // timer c pulse
    int failures = 0; // mismatches
    int tests_run = 0; // comparisons
    logic [31:0] d; // scratch read data
    logic e; // scratch error
    tbi_top i_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .sub_clk_pin(sub_clk_pin), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .ta_ovf_flag(ta_ovf_flag),
        .tc_ovf_flag(tc_ovf_flag), .tc_ovf_pulse(tc_ovf_pulse));
    // 100 mhz clock
    always #5 pclk = ~pclk;
    // compare one value, four-state exact
    task automatic chk(input string what, input logic [31:0] x,
        input logic [31:0] y);
        tests_run++;
        if (y !== x) begin
            failures++;
            $display("[ERR] %s expected %h seen %h", what, x, y);
        end
    endtask
    // one apb transfer; waits for pready, bounded
    task automatic apb(input logic [17:0] idx, input logic w,
        input logic [31:0] wd, output logic [31:0] rd, output logic er);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= {idx, 2'b00};
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1 && n < 50) begin
            @(posedge pclk);
            n++;
        end
        if (n == 50) failures++;
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    // cycles between two overflow pulses; waits are bounded
    task automatic period(input int x, input string what);
        int n;
        n = 0;
        // skip a pulse left over from the mode in force before the call
        do begin
            @(posedge pclk);
            n++;
        end while (tc_ovf_pulse !== 1'b1 && n < 20000);
        if (n >= 20000) failures++;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (tc_ovf_pulse !== 1'b1 && n < 20000);
        chk(what, x, n);
    endtask
    // sub-clock burst of k edges, 4 pclk each, then time to sync;
    // an empty burst idles long enough for a wrong phi source to show
    task automatic sub(input int k);
        repeat (k) begin
            sub_clk_pin <= 1'b1;
            repeat (2) @(posedge pclk);
            sub_clk_pin <= 1'b0;
            repeat (2) @(posedge pclk);
        end
        repeat ((k == 0) ? 3000 : 6) @(posedge pclk);
    endtask
    // timer a count advance over k sub edges with mode m
    task automatic tb_step(input logic [7:0] m, input int k, input int x);
        logic [7:0] c;
        apb(`TBI_IDX_TA_MODE, 1'b1, {24'h0, m}, d, e);
        apb(`TBI_IDX_COUNT, 1'b0, 32'h0, d, e);
        c = d[7:0];
        sub(k);
        apb(`TBI_IDX_COUNT, 1'b0, 32'h0, d, e);
        chk("timer a advance", x, {24'h0, d[7:0] - c});
    endtask
    // mode reset values, timer c mode mask, load register and unmapped index
    task automatic t_regs();
        apb(`TBI_IDX_TA_MODE, 1'b0, 32'h0, d, e);
        chk("ta mode reset", 32'h0, d);
        apb(`TBI_IDX_TC_MODE, 1'b0, 32'h0, d, e);
        chk("tc mode reset", 32'h0, d);
        apb(`TBI_IDX_TC_MODE, 1'b1, 32'hff, d, e);
        apb(`TBI_IDX_TC_MODE, 1'b0, 32'h0, d, e);
        chk("tc mode mask", 32'he7, d);
        apb(`TBI_IDX_TC_LOAD, 1'b1, 32'ha5, d, e);
        apb(`TBI_IDX_TC_LOAD, 1'b0, 32'h0, d, e);
        chk("load reg", 32'ha5, d);
        apb(18'h0ffb1, 1'b0, 32'h0, d, e);
        chk("unmapped err", 32'h1, {31'h0, e});
        $display("done regs");
    endtask
    // timer c free run, up, phi/2, then reload and phi/64
    task automatic t_tc();
        apb(`TBI_IDX_TC_MODE, 1'b1, 32'h06, d, e);
        period(10240, "free period");
        apb(`TBI_IDX_STATUS, 1'b1, 32'h2, d, e);
        apb(`TBI_IDX_STATUS, 1'b0, 32'h0, d, e);
        chk("tc flag cleared", 32'h0, {31'h0, d[1]});
        apb(`TBI_IDX_TC_LOAD, 1'b1, 32'hf0, d, e);
        apb(`TBI_IDX_TC_MODE, 1'b1, 32'h86, d, e);
        period(640, "reload period");
        chk("tc flag", 32'h1, {31'h0, tc_ovf_flag});
        apb(`TBI_IDX_TC_LOAD, 1'b1, 32'hfc, d, e);
        // let one fast wrap load the new value before slowing down
        repeat (700) @(posedge pclk);
        apb(`TBI_IDX_TC_MODE, 1'b1, 32'h83, d, e);
        period(5120, "phi64 period");
        $display("done timer c");
    endtask
    // time base: sub-clock driven, still clock, held reset
    task automatic t_ta();
        tb_step(8'h09, 192, 3);
        tb_step(8'h0b, 48, 3);
        tb_step(8'h0b, 0, 0);
        tb_step(8'h0c, 64, 0);
        chk("ta held", 32'h0, {24'h0, d[7:0]});
        // from a held zero, 255 counts stay short of the overflow
        apb(`TBI_IDX_STATUS, 1'b1, 32'h1, d, e);
        apb(`TBI_IDX_TA_MODE, 1'b1, 32'h0b, d, e);
        sub(4080);
        chk("ta flag early", 32'h0, {31'h0, ta_ovf_flag});
        sub(16);
        chk("ta flag", 32'h1, {31'h0, ta_ovf_flag});
        apb(`TBI_IDX_STATUS, 1'b1, 32'h1, d, e);
        apb(`TBI_IDX_STATUS, 1'b0, 32'h0, d, e);
        chk("ta flag cleared", 32'h0, {31'h0, d[0]});
        $display("done timer a");
    endtask
    // counts, verdict and end of run
    task automatic end_sim();
        $display("comparisons %0d mismatches %0d", tests_run, failures);
        if (failures == 0 && tests_run > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    // main sequence
    initial begin
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        t_regs();
        t_tc();
        t_ta();
        end_sim();
    end
    // watchdog, somewhat above the expected run of about 60000 cycles
    initial begin
        repeat (90000) @(posedge pclk);
        failures++;
        end_sim();
    end
endmodule
